// file: core/pcfg_map.svh
// Purpose: Register offsets, field positions and reset values for the port config block
// Assumes: APB byte addresses, one aligned 32-bit word per 8-bit register
// Notes:   Offsets are printed register indices times four
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH

`define PCFG_IDX_UPCTL    8'he1
`define PCFG_IDX_DATA     8'he3
`define PCFG_IDX_PUEN     8'hf4
`define PCFG_IDX_CTL      8'hef
`define PCFG_IDX_P4MODE   8'hf0

`define PCFG_RST_UPCTL    8'h50
`define PCFG_RST_DATA     8'h00
`define PCFG_RST_PUEN     8'h00
`define PCFG_RST_CTL      8'h00
`define PCFG_RST_P4MODE   8'h00

`define PCFG_MASK_UPCTL   8'hf1
`define PCFG_MASK_DATA    8'hbf
`define PCFG_MASK_PUEN    8'h33

`define PCFG_CTL_ALTSEL   7:6
`define PCFG_CTL_P31FS    5
`define PCFG_CTL_P31MODE  4:3
`define PCFG_CTL_P30FS    2
`define PCFG_CTL_P30MODE  1:0
`define PCFG_UP_P35MODE   7:6
`define PCFG_UP_P34MODE   5:4
`define PCFG_UP_P4SEL     0
`define PCFG_DATA_CARRIER 7

`endif

// file: core/pcfg_pkg.sv
// Purpose: Types shared by the port config block
// Assumes: Nothing
// Notes:   Mode encodings common to all two-bit pin mode fields
package pcfg_pkg;
  typedef enum logic [1:0] {
    PCFG_IN       = 2'b00,
    PCFG_OD       = 2'b01,
    PCFG_PP       = 2'b10,
    PCFG_IN_PU    = 2'b11
  } pcfg_mode_t;

  typedef struct packed {
    logic oe;
    logic od;
    logic pu;
  } pcfg_pin_t;
endpackage : pcfg_pkg

// file: core/pcfg_pin_drv.sv
// Purpose: Turn one two-bit pin mode into drive, open-drain and pull-up controls
// Assumes: Output data comes from the caller
// Notes:   Registered outputs; settle one cycle after the mode changes
`timescale 1ns/1ps
module pcfg_pin_drv
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Configuration
  input  wire logic [1:0] mode,
  input  wire logic       outPu,
  input  wire logic       dout,
  input  wire logic       forceIn,
  // Pin side
  output logic            pinOut,
  output logic            pinOe,
  output logic            pinPu
);
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } pcfg_drv_t;

  pcfg_drv_t state_ff;
  pcfg_drv_t nxt_state;

  always_comb begin
    nxt_state = '0;
    if (forceIn) begin
      nxt_state.pu = 1'b0;
    end else begin
      case (pcfg_mode_t'(mode))
        PCFG_OD: begin
          // Open drain only pulls low; high level comes from the pull-up
          nxt_state.o  = 1'b0;
          nxt_state.oe = ~dout;
          nxt_state.pu = outPu;
        end
        PCFG_PP: begin
          nxt_state.o  = dout;
          nxt_state.oe = 1'b1;
          nxt_state.pu = outPu;
        end
        PCFG_IN_PU: nxt_state.pu = 1'b1;
        default:    nxt_state.pu = 1'b0;
      endcase
    end
    if (rst) begin
      nxt_state = '0;
    end
  end

  always_ff @(posedge mclk) begin
    state_ff <= nxt_state;
  end

  assign pinOut = state_ff.o;
  assign pinOe  = state_ff.oe;
  assign pinPu  = state_ff.pu;
endmodule : pcfg_pin_drv

// file: core/pcfg_alt_route.sv
// Purpose: Alternative function routing for port 3 pins 0 to 3
// Assumes: Control byte is the port 3 control register
// Notes:   Pure decode; caller registers the results
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_alt_route
  import pcfg_pkg::*;
(
  // Control
  input  wire logic [7:0] ctl,
  // Routing results
  output logic            p0Pwm,
  output logic            p0Cap,
  output logic            p1Rem,
  output logic            p1ForceIn,
  output logic            p2Tck,
  output logic            p3Cap,
  output logic            spread
);
  function automatic logic isOut(input logic [1:0] m);
    isOut = (m == PCFG_OD) || (m == PCFG_PP);
  endfunction : isOut

  always_comb begin
    spread    = (ctl[`PCFG_CTL_ALTSEL] != 2'b00);
    p0Pwm     = ctl[`PCFG_CTL_P30FS] & isOut(ctl[`PCFG_CTL_P30MODE]);
    p0Cap     = ctl[`PCFG_CTL_P30FS] & ~isOut(ctl[`PCFG_CTL_P30MODE]);
    p1Rem     = ctl[`PCFG_CTL_P31FS] & isOut(ctl[`PCFG_CTL_P31MODE]);
    p1ForceIn = ctl[`PCFG_CTL_P31FS] & ~isOut(ctl[`PCFG_CTL_P31MODE]);
    p2Tck     = ctl[`PCFG_CTL_P31FS];
    p3Cap     = ctl[`PCFG_CTL_P30FS];
  end
endmodule : pcfg_alt_route

// file: core/pcfg_port_config.sv
// Purpose: Port 3 and port 4 pin configuration registers and pin multiplexing
// Assumes: APB slave, 8-bit registers in the low byte, one clock, sync reset
// Notes:   Pins drive three signals each; the pad ring resolves the wire
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "pcfg_map.svh"

// What this block does
// (R1) Control bit 2 clear keeps pins 0,3 normal; set routes PWM/capture.
// (R2) Control bits 1:0 select pin 0 mode: input, open-drain, push-pull, pulled input.
// (R3) Data register holds seven bits; bit 6 unused, reads zero.
// (R4) Data bit 7 switches the carrier signal on or off.
// (R5) Data bits 1,0 drive pins 1 and 0.
// (R6) Pins 2,3 are inputs only with pull-up always on.
// (R7) Pins 4,5 are digital I/O per upper control modes.
// (R8) Only function select bits 5 and 2 enable alternative functions.
// (R9) Bit 2 set: pin 0 PWM when output mode, capture otherwise; pin 3 capture.
// (R10) Bit 5 set: pin 2 timer clock; pin 1 carrier when output mode.
// (R11) Upper control bits 7:6 select pin 5 mode.
// (R12) Upper control bits 5:4 select pin 4 mode.
// (R13) Upper control bits 3:1 unimplemented, no effect.
// (R14) Upper control bit 0 selects single or paired port 4 mode registers.
// (R15) Upper control resets to 50h.
// (R16) Software sets upper bit 0 to use port 4 as inputs.
// (R17) Pull-up enable bits 5,4,1,0 enable output-mode pull-ups; others unused.
// (R18) Port 4 mode bit n: 0 open-drain, 1 push-pull; resets zero.
// (R19) Control bit 5 clear keeps pin 1 normal; set enables carrier/clock.
// (R20) Control bits 4:3 select pin 1 mode.
// (R21) Control bits 7:6 nonzero spread functions over pins 0 to 3.
// (R22) Registers written synchronously; new modes act the cycle after the write.
module pcfg_port_config
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer and carrier sources
  input  wire logic        timer0PwmOut,
  input  wire logic        remoteCarrierOut,
  // Port 3 pins
  input  wire logic [5:0]  p3PinIn,
  output logic      [5:0]  p3PinOut,
  output logic      [5:0]  p3PinOe,
  output logic      [5:0]  p3PinPu,
  // Captured inputs to timers, and carrier enable
  output logic             timer0CaptureIn,
  output logic             timer1CaptureIn,
  output logic             timer2CaptureIn,
  output logic             timer0ClockIn,
  output logic             carrierOn,
  // Port 4 mode controls
  output logic             port4PairedSel,
  output logic      [7:0]  port4PushPull
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  upctl;
    logic [7:0]  data;
    logic [7:0]  puen;
    logic [7:0]  p4mode;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [3:0]  meta;
    logic [3:0]  sync;
    logic [2:0]  capOut;
    logic        ckOut;
    logic [1:0]  p23Out;
  } pcfg_state_t;

  pcfg_state_t state_ff;
  pcfg_state_t nxt_state;

  logic p0Pwm, p0Cap, p1Rem, p1ForceIn, p2Tck, p3Cap, spread;
  logic d0, d1;

  function automatic logic [7:0] regIdx(input logic [11:0] a);
    regIdx = a[9:2];
  endfunction : regIdx

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) && (regIdx(a) == idx);
  endfunction : hit

  pcfg_alt_route u_route (
    .ctl       (state_ff.ctl),
    .p0Pwm     (p0Pwm),
    .p0Cap     (p0Cap),
    .p1Rem     (p1Rem),
    .p1ForceIn (p1ForceIn),
    .p2Tck     (p2Tck),
    .p3Cap     (p3Cap),
    .spread    (spread)
  );

  // Pin 0 output source: timer PWM when routed, else data bit
  assign d0 = p0Pwm ? timer0PwmOut : state_ff.data[0]; // (R9) (R5)
  // Pin 1 output source: carrier when routed, else data bit
  assign d1 = p1Rem ? remoteCarrierOut : state_ff.data[1]; // (R10) (R5)

  pcfg_pin_drv u_p0 (
    .mclk    (mclk),
    .rst     (rst),
    .mode    (state_ff.ctl[`PCFG_CTL_P30MODE]), // (R2)
    .outPu   (state_ff.puen[0]), // (R17)
    .dout    (d0),
    .forceIn (1'b0),
    .pinOut  (p3PinOut[0]),
    .pinOe   (p3PinOe[0]),
    .pinPu   (p3PinPu[0])
  );

  // Pin 1 falls back to plain input when alt enabled in an input mode
  pcfg_pin_drv u_p1 (
    .mclk    (mclk),
    .rst     (rst),
    .mode    (state_ff.ctl[`PCFG_CTL_P31MODE]), // (R20)
    .outPu   (state_ff.puen[1]), // (R17)
    .dout    (d1),
    .forceIn (p1ForceIn), // (R10) (R19)
    .pinOut  (p3PinOut[1]),
    .pinOe   (p3PinOe[1]),
    .pinPu   (p3PinPu[1])
  );

  genvar g;
  generate
    for (g = 4; g < 6; g++) begin : g_hi
      pcfg_pin_drv u_ph (
        .mclk    (mclk),
        .rst     (rst),
        .mode    (state_ff.upctl[2*g-3 -: 2]), // (R11) (R12) (R7)
        .outPu   (state_ff.puen[g]), // (R17)
        .dout    (state_ff.data[g]),
        .forceIn (1'b0),
        .pinOut  (p3PinOut[g]),
        .pinOe   (p3PinOe[g]),
        .pinPu   (p3PinPu[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.ready  = 1'b0;
    nxt_state.err    = 1'b0;
    nxt_state.rdata  = 32'h0;
    // Two-stage synchroniser for pins 0 to 3; only the second stage is read
    nxt_state.meta   = p3PinIn[3:0];
    nxt_state.sync   = state_ff.meta;
    // Registers change only on the access phase of an APB write
    if (psel && !penable) begin
      nxt_state.ready = 1'b1;
      nxt_state.err   = !(hit(paddr, `PCFG_IDX_CTL) || hit(paddr, `PCFG_IDX_UPCTL) ||
                          hit(paddr, `PCFG_IDX_DATA) || hit(paddr, `PCFG_IDX_PUEN) ||
                          hit(paddr, `PCFG_IDX_P4MODE));
      if (!pwrite) begin
        case (regIdx(paddr))
          `PCFG_IDX_CTL:    nxt_state.rdata = {24'h0, state_ff.ctl};
          `PCFG_IDX_UPCTL:  nxt_state.rdata = {24'h0, state_ff.upctl};
          `PCFG_IDX_DATA:   nxt_state.rdata = {24'h0, state_ff.data[7:4],
                                               state_ff.sync[3:2], state_ff.data[1:0]};
          `PCFG_IDX_PUEN:   nxt_state.rdata = {24'h0, state_ff.puen};
          `PCFG_IDX_P4MODE: nxt_state.rdata = {24'h0, state_ff.p4mode};
          default:          nxt_state.rdata = 32'h0;
        endcase
        if (nxt_state.err) begin
          nxt_state.rdata = 32'h0;
        end
      end
    end
    if (psel && penable && state_ff.ready && pwrite && !state_ff.err && pstrb[0]) begin // (R22)
      if (hit(paddr, `PCFG_IDX_CTL)) begin
        nxt_state.ctl = pwdata[7:0];
      end
      if (hit(paddr, `PCFG_IDX_UPCTL)) begin
        nxt_state.upctl = pwdata[7:0] & `PCFG_MASK_UPCTL; // (R13)
      end
      if (hit(paddr, `PCFG_IDX_DATA)) begin
        nxt_state.data = pwdata[7:0] & `PCFG_MASK_DATA; // (R3)
      end
      if (hit(paddr, `PCFG_IDX_PUEN)) begin
        nxt_state.puen = pwdata[7:0] & `PCFG_MASK_PUEN; // (R17)
      end
      if (hit(paddr, `PCFG_IDX_P4MODE)) begin
        nxt_state.p4mode = pwdata[7:0]; // (R18)
      end
    end
    // Captured inputs only while routed, so idle timers see a quiet zero
    nxt_state.capOut[0] = p0Cap & state_ff.sync[0]; // (R1) (R9)
    // Combined mapping stacks every capture on pin 0 when spread is off
    nxt_state.capOut[1] = p3Cap & (spread ? state_ff.sync[3] : state_ff.sync[0]); // (R8) (R21)
    nxt_state.capOut[2] = p3Cap & (spread ? state_ff.sync[3] : state_ff.sync[0]); // (R9) (R21)
    // Combined mapping stacks the clock on pin 1 when spread is off
    nxt_state.ckOut     = p2Tck & (spread ? state_ff.sync[2] : state_ff.sync[1]); // (R10) (R21)
    if (rst) begin
      nxt_state        = '0;
      nxt_state.upctl  = `PCFG_RST_UPCTL; // (R15)
      nxt_state.ctl    = `PCFG_RST_CTL;
      nxt_state.data   = `PCFG_RST_DATA;
      nxt_state.puen   = `PCFG_RST_PUEN;
      nxt_state.p4mode = `PCFG_RST_P4MODE; // (R18)
    end
  end

  always_ff @(posedge mclk) begin
    state_ff <= nxt_state;
  end

  // Pins 2 and 3 are never driven; pull-up fixed on
  assign p3PinOut[3:2] = 2'b00; // (R6)
  assign p3PinOe[3:2]  = 2'b00; // (R6)
  assign p3PinPu[3:2]  = 2'b11; // (R6)

  assign prdata          = state_ff.rdata;
  assign pready          = state_ff.ready;
  assign pslverr         = state_ff.err;
  assign timer0CaptureIn = state_ff.capOut[0];
  assign timer1CaptureIn = state_ff.capOut[1];
  assign timer2CaptureIn = state_ff.capOut[2];
  assign timer0ClockIn   = state_ff.ckOut;
  assign carrierOn       = state_ff.data[`PCFG_DATA_CARRIER]; // (R4)
  assign port4PairedSel  = state_ff.upctl[`PCFG_UP_P4SEL]; // (R14) (R16)
  assign port4PushPull   = state_ff.p4mode; // (R18)
endmodule : pcfg_port_config

// file: verif/pcfg_port_config_properties.sv
// Purpose: Port-level properties of the port config block
// Assumes: Bound to pcfg_port_config, one clock, sync reset
// Notes:   Pin timing is left to the bench, which knows the pin stimulus
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_port_config_properties
  import pcfg_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and controls
  input wire logic [5:0]  p3PinOe,
  input wire logic [5:0]  p3PinPu,
  input wire logic        carrierOn,
  input wire logic        port4PairedSel,
  input wire logic [7:0]  port4PushPull
);
  localparam logic [11:0] AUp  = {2'b00, `PCFG_IDX_UPCTL, 2'b00};
  localparam logic [11:0] ADat = {2'b00, `PCFG_IDX_DATA, 2'b00};
  localparam logic [11:0] AP4  = {2'b00, `PCFG_IDX_P4MODE, 2'b00};
  logic wrAcc;
  // Only an accepted, error-free access with byte 0 enabled may change a register
  assign wrAcc = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error without ready or with data");
  a_fixed_inputs: assert property (p3PinOe[3:2] == 2'b00 && p3PinPu[3:2] == 2'b11)
    else $error("pins 2 and 3 not pulled inputs");
  a_reset_values: assert property ($fell(rst) |->
    port4PushPull == 8'h00 && !port4PairedSel)
    else $error("port 4 controls not cleared by reset");
  a_carrier_write: assert property (wrAcc && paddr == ADat |=>
    carrierOn == $past(pwdata[7]))
    else $error("carrier does not follow data bit 7");
  a_p4mode_write: assert property (wrAcc && paddr == AP4 |=>
    port4PushPull == $past(pwdata[7:0]))
    else $error("port 4 mode not written");
  a_paired_write: assert property (wrAcc && paddr == AUp |=>
    port4PairedSel == $past(pwdata[0]))
    else $error("port 4 select not written");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above byte 0");
endmodule : pcfg_port_config_properties

bind pcfg_port_config pcfg_port_config_properties u_props (.mclk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .p3PinOe, .p3PinPu,
  .carrierOn, .port4PairedSel, .port4PushPull);

// file: verif/pcfg_port_config_tb.sv
// Purpose: Self-checking bench for the port config block
// Assumes: APB master in this bench, zero-wait slave
// Notes:   Pin checks wait four edges, past the register and pin stages
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_port_config_tb
  import pcfg_pkg::*;
;
  localparam logic [11:0] AUp  = {2'b00, `PCFG_IDX_UPCTL, 2'b00};
  localparam logic [11:0] ADat = {2'b00, `PCFG_IDX_DATA, 2'b00};
  localparam logic [11:0] APu  = {2'b00, `PCFG_IDX_PUEN, 2'b00};
  localparam logic [11:0] ACtl = {2'b00, `PCFG_IDX_CTL, 2'b00};
  localparam logic [11:0] AP4  = {2'b00, `PCFG_IDX_P4MODE, 2'b00};
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic        timer0PwmOut, remoteCarrierOut, carrierOn, port4PairedSel;
  logic        timer0CaptureIn, timer1CaptureIn, timer2CaptureIn, timer0ClockIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [5:0]  p3PinIn, p3PinOut, p3PinOe, p3PinPu;
  logic [7:0]  port4PushPull;
  int          miscompares, checksDone, cycles;

  pcfg_port_config uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .timer0PwmOut, .remoteCarrierOut, .p3PinIn, .p3PinOut,
    .p3PinOe, .p3PinPu, .timer0CaptureIn, .timer1CaptureIn, .timer2CaptureIn,
    .timer0ClockIn, .carrierOn, .port4PairedSel, .port4PushPull);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // A hang in a wait loop ends here instead of running forever
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Called just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, 4'h1, r, e);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    check(r, x);
  endtask : rdchk

  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask : settle

  task automatic t_reset;
    rdchk(AUp, 32'h50);
    rdchk(ACtl, 32'h0);
    rdchk(AP4, 32'h0);
    rdchk(APu, 32'h0);
    rdchk(ADat, 32'h0);
    check(32'({p3PinOe[5:4], p3PinOut[5:4]}), 32'hc);
    $display("reset test done");
  endtask : t_reset

  task automatic t_masks;
    logic [31:0] r;
    logic        e;
    wr(AUp, 8'hff);
    wr(ADat, 8'hff);
    wr(APu, 8'hff);
    rdchk(AUp, 32'hf1);
    rdchk(ADat, 32'hb3);
    rdchk(APu, 32'h33);
    apb(1'b0, 12'h004, 32'h0, 4'h0, r, e);
    check(32'(e), 32'h1);
    apb(1'b1, AP4, 32'hff, 4'h0, r, e);
    rdchk(AP4, 32'h0);
    $display("mask test done");
  endtask : t_masks

  task automatic t_upper;
    for (int m = 0; m < 4; m++) begin
      wr(AUp, {m[1:0], m[1:0], 4'h0});
      settle;
      check(32'({p3PinOe[5:4], p3PinPu[5:4]}), 32'({{2{m == 2}}, {2{m != 0}}}));
    end
    wr(AUp, 8'h50);
    wr(ADat, 8'h00);
    settle;
    check(32'({p3PinOe[5:4], p3PinOut[5:4]}), 32'hc);
    $display("upper mode test done");
  endtask : t_upper

  task automatic t_pin0;
    wr(ADat, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(ACtl, {3'b000, m[1:0], 1'b0, m[1:0]});
      settle;
      check(32'({p3PinOe[1:0], p3PinPu[1:0]}), 32'({{2{m == 2}}, {2{m != 0}}}));
    end
    wr(ACtl, 8'h12);
    wr(ADat, 8'h02);
    settle;
    check(32'(p3PinOut[1:0]), 32'h2);
    timer0PwmOut <= 1'b1;
    wr(ACtl, 8'h06);
    settle;
    check(32'({p3PinOe[0], p3PinOut[0]}), 32'h3);
    timer0PwmOut <= 1'b0;
    settle;
    check(32'(p3PinOut[0]), 32'h0);
    // Spread off: every capture comes from pin 0
    wr(ACtl, 8'h04);
    p3PinIn <= 6'h01;
    settle;
    check(32'({timer0CaptureIn, timer1CaptureIn, timer2CaptureIn}), 32'h7);
    // Spread on: timer 1 and 2 captures move to pin 3
    wr(ACtl, 8'h44);
    p3PinIn <= 6'h08;
    settle;
    check(32'({timer0CaptureIn, timer1CaptureIn, timer2CaptureIn}), 32'h3);
    wr(ACtl, 8'h00);
    settle;
    check(32'({timer0CaptureIn, timer1CaptureIn}), 32'h0);
    $display("pin 0 test done");
  endtask : t_pin0

  task automatic t_pin1;
    remoteCarrierOut <= 1'b1;
    wr(ACtl, 8'h70);
    p3PinIn <= 6'h04;
    settle;
    check(32'({p3PinOut[1], p3PinOe[1], timer0ClockIn}), 32'h7);
    wr(ACtl, 8'h20);
    p3PinIn <= 6'h02;
    settle;
    check(32'({p3PinOe[1], timer0ClockIn}), 32'h1);
    $display("pin 1 test done");
  endtask : t_pin1

  task automatic t_p4;
    wr(AP4, 8'ha5);
    check(32'(port4PushPull), 32'ha5);
    wr(AUp, 8'h51);
    check(32'(port4PairedSel), 32'h1);
    wr(ADat, 8'h80);
    check(32'(carrierOn), 32'h1);
    wr(ADat, 8'h00);
    check(32'(carrierOn), 32'h0);
    $display("port 4 test done");
  endtask : t_p4

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    timer0PwmOut = 1'b0;
    remoteCarrierOut = 1'b0;
    p3PinIn = 6'h00;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_masks;
    t_upper;
    t_pin0;
    t_pin1;
    t_p4;
    p3PinIn <= 6'h00;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    settle;
    t_reset;
    final_report;
  end
endmodule : pcfg_port_config_tb
